// ==== hw/flash_write_protect_and_reset.sv ====
// command-level write latch, block protection and software reset of a serial flash
// assumes an spi host on the link pins and an array sequencer on ref_clk
`timescale 1ns/1ps
module flash_write_protect_and_reset
  import fwp_pkg::*;
(
  // system
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // spi link
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  input wire logic wp_n_in,
  // array sequencer
  input wire logic op_done_in,
  output logic op_start_out,
  output logic [7:0] op_code_out,
  output logic [23:0] op_addr_out,
  // status
  output logic write_latch_out,
  output protect_s protect_out,
  output logic ready_busy_flag_out,
  output logic reset_active_out,
  output logic volatile_clear_out
);
  frame_s frame;
  logic frame_tog;
  range_s prot_range;
  logic cs_meta_reg;
  logic cs_sync_reg;
  logic cs_seen_reg;
  logic tog_meta_reg;
  logic tog_sync_reg;
  logic tog_seen_reg;
  logic wp_meta_reg;
  logic wp_sync_reg;
  logic frame_end;
  ctrl_state_e state_reg;
  ctrl_state_e state_next;
  logic write_latch_reg;
  protect_s protect_reg;
  logic reset_arm_reg;
  logic [9:0] reset_cnt_reg;
  logic op_ok;
  logic is_guarded;
  logic is_array;
  logic hit;
  logic [18:0] reg_lo;
  logic [18:0] reg_hi;
  logic latch_set_cmd;
  logic latch_clr_cmd;
  logic status_cmd;
  logic reset_go;

  spi_frame_capture u_capture (
    .sclk_in(sclk_in),
    .cs_n_in(cs_n_in),
    .mosi_in(mosi_in),
    .nrst_in(nrst_in),
    .frame_out(frame),
    .frame_tog_out(frame_tog)
  );

  protect_range_decode u_decode (
    .protect_in(protect_reg),
    .range_out(prot_range)
  );

  // two-stage synchronisers for chip select, frame toggle and the write-protect pin
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      tog_meta_reg <= 1'b0;
      tog_sync_reg <= 1'b0;
      wp_meta_reg <= 1'b1;
      wp_sync_reg <= 1'b1;
    end
    else
    begin
      cs_meta_reg <= cs_n_in;
      cs_sync_reg <= cs_meta_reg;
      tog_meta_reg <= frame_tog;
      tog_sync_reg <= tog_meta_reg;
      wp_meta_reg <= wp_n_in;
      wp_sync_reg <= wp_meta_reg;
    end
  end

  // edge memory; the toggle settles before chip select rises, so it is current
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cs_seen_reg <= 1'b1;
      tog_seen_reg <= 1'b0;
    end
    else
    begin
      cs_seen_reg <= cs_sync_reg;
      if (frame_end)
        tog_seen_reg <= tog_sync_reg;
    end
  end

  // a frame ends when chip select rises after at least one clock edge;
  // the frame fields are held still by the stopped link clock while we read them
  assign frame_end = cs_sync_reg && !cs_seen_reg && (tog_sync_reg != tog_seen_reg);

  // opcode classes; latch opcodes accept trailing whole bytes
  assign latch_set_cmd = frame.aligned && frame.opcode == OP_LATCH_SET;
  assign latch_clr_cmd = frame.aligned && frame.opcode == OP_LATCH_CLR;
  assign status_cmd = frame.aligned && frame.opcode == OP_STATUS_WR &&
                      frame.nbytes >= BYTES_STATUS;

  // region touched by a program or erase
  always_comb
  begin
    is_guarded = 1'b1;
    is_array = 1'b1;
    reg_lo = frame.addr[18:0] & ~MASK_PAGE;
    reg_hi = frame.addr[18:0] | MASK_PAGE;
    op_ok = frame.aligned && frame.nbytes == BYTES_ERASE;
    case (frame.opcode)
      OP_PROGRAM:
        op_ok = frame.aligned && frame.nbytes >= BYTES_PROGRAM;
      OP_ERASE_4K:
      begin
        reg_lo = frame.addr[18:0] & ~MASK_4K;
        reg_hi = frame.addr[18:0] | MASK_4K;
      end
      OP_ERASE_32K:
      begin
        reg_lo = frame.addr[18:0] & ~MASK_32K;
        reg_hi = frame.addr[18:0] | MASK_32K;
      end
      OP_ERASE_64K:
      begin
        reg_lo = frame.addr[18:0] & ~MASK_64K;
        reg_hi = frame.addr[18:0] | MASK_64K;
      end
      OP_ERASE_CHIP_A, OP_ERASE_CHIP_B:
      begin
        reg_lo = 19'h00000;
        reg_hi = ARRAY_TOP;
        op_ok = frame.aligned && frame.nbytes >= BYTES_OPCODE;
      end
      OP_SEC_PROGRAM:
      begin
        is_array = 1'b0;
        op_ok = frame.aligned && frame.nbytes >= BYTES_PROGRAM;
      end
      OP_SEC_ERASE:
        is_array = 1'b0;
      default:
      begin
        is_guarded = 1'b0;
        is_array = 1'b0;
        op_ok = 1'b0;
      end
    endcase
  end

  assign hit = is_array && overlaps(reg_lo, reg_hi, prot_range);

  // execute only when the complete command just before it was the arm opcode
  assign reset_go = frame_end && frame.aligned && frame.opcode == OP_RESET_EXEC &&
                    reset_arm_reg;

  // control state machine
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (reset_go)
          state_next = ST_RESET;
        else if (frame_end && is_guarded && op_ok && write_latch_reg && !hit)
          state_next = ST_BUSY;
      ST_BUSY:
        if (reset_go)
          state_next = ST_RESET;
        else if (op_done_in)
          state_next = ST_IDLE;
      ST_RESET:
        if (reset_cnt_reg == RESET_LAST)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // recovery counter; frames during recovery are dropped whole
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      reset_cnt_reg <= 10'h000;
    else if (state_reg == ST_RESET)
      reset_cnt_reg <= reset_cnt_reg + 10'h001;
    else
      reset_cnt_reg <= 10'h000;
  end

  // reset arm: any other complete command in between disarms
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      reset_arm_reg <= 1'b0;
    else if (state_reg == ST_RESET)
      reset_arm_reg <= 1'b0;
    else if (frame_end && frame.aligned)
      reset_arm_reg <= (frame.opcode == OP_RESET_ARM);
  end

  // write latch; busy frames may still toggle it but cannot start work
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      write_latch_reg <= WEL_RESET;
    else if (state_next == ST_RESET)
      write_latch_reg <= WEL_RESET;
    else if (state_reg == ST_RESET)
      write_latch_reg <= write_latch_reg;
    else if (state_reg == ST_IDLE && state_next == ST_BUSY)
      write_latch_reg <= 1'b0;
    else if (frame_end && latch_set_cmd)
      write_latch_reg <= 1'b1;
    else if (frame_end && latch_clr_cmd)
      write_latch_reg <= 1'b0;
    else if (frame_end && status_cmd && state_reg == ST_IDLE && write_latch_reg)
      write_latch_reg <= 1'b0;
  end

  // protection bits are non-volatile in spirit: a software reset keeps them;
  // the pin only gates the update path, it never touches the decoded range
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      protect_reg <= PROTECT_RESET;
    else if (frame_end && status_cmd && state_reg == ST_IDLE && write_latch_reg &&
             wp_sync_reg)
    begin
      {protect_reg.granularity, protect_reg.bottom, protect_reg.size} <=
        frame.data1[BP_LSB +: 5];
      if (frame.nbytes >= BYTES_STATUS_CMP)
        protect_reg.complement <= frame.data2[CMP_BIT];
    end
  end

  // operation hand-off to the array sequencer
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      op_start_out <= 1'b0;
      op_code_out <= 8'h00;
      op_addr_out <= 24'h000000;
    end
    else
    begin
      op_start_out <= (state_reg == ST_IDLE && state_next == ST_BUSY);
      if (state_reg == ST_IDLE && state_next == ST_BUSY)
      begin
        op_code_out <= frame.opcode;
        op_addr_out <= frame.addr;
      end
    end
  end

  // status outputs, one register stage each
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      write_latch_out <= WEL_RESET;
      protect_out <= PROTECT_RESET;
      ready_busy_flag_out <= 1'b0;
      reset_active_out <= 1'b0;
      volatile_clear_out <= 1'b0;
    end
    else
    begin
      write_latch_out <= write_latch_reg;
      protect_out <= protect_reg;
      ready_busy_flag_out <= (state_reg != ST_IDLE);
      reset_active_out <= (state_reg == ST_RESET);
      volatile_clear_out <= (state_reg != ST_RESET && state_next == ST_RESET);
    end
  end

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  wel_set_a: assert property (frame_end && latch_set_cmd && state_reg == ST_IDLE &&
    !reset_go |=> write_latch_reg) else $error("latch not set");
  wel_clear_a: assert property (frame_end && latch_clr_cmd && state_reg != ST_RESET
    |=> !write_latch_reg) else $error("latch not cleared");
  guarded_start_a: assert property (op_start_out |-> $past(write_latch_reg, 1) &&
    !write_latch_reg) else $error("op started without latch");
  partial_hold_a: assert property (frame_end && !frame.aligned && state_reg == ST_IDLE
    |=> $stable(write_latch_reg)) else $error("partial frame moved latch");
  wp_freeze_a: assert property (!wp_sync_reg |=> $stable(protect_reg))
    else $error("protection changed under wp");
  prot_path_a: assert property (!$stable(protect_reg) |-> $past(frame_end) &&
    $past(frame.opcode) == OP_STATUS_WR) else $error("protection changed");
  prot_hit_a: assert property (frame_end && hit |=> state_reg != ST_BUSY ||
    $past(state_reg) == ST_BUSY) else $error("protected op accepted");
  arm_cancel_a: assert property (frame_end && frame.aligned &&
    frame.opcode != OP_RESET_ARM |=> !reset_arm_reg) else $error("arm kept");
  reset_hold_a: assert property ($rose(reset_active_out) |-> reset_active_out[*8])
    else $error("reset too short");
  reset_end_a: assert property (state_reg == ST_RESET && reset_cnt_reg == RESET_LAST
    |=> state_reg == ST_IDLE) else $error("reset length wrong");
  reset_clear_a: assert property (volatile_clear_out |-> !write_latch_reg &&
    state_reg == ST_RESET) else $error("reset did not clear");
endmodule

// ==== hw/fwp_pkg.sv ====
// constants, carriers and the opcode set of the write-protect and reset logic
// assumes a 25 MHz system clock and an spi link clocked by the host
// Summary of operation
// - complete enable opcode sets the write latch
// - guarded commands need latch set on arrival
// - latch opcodes ignore trailing whole bytes
// - partial or misaligned frame leaves latch unchanged
// - complete disable opcode clears the write latch
// - latch clear blocks program, erase, status write
// - protection bits change only by status write
// - plain decode, coarse granularity eighth steps
// - plain decode, fine granularity kilobyte steps
// - complement bit inverts the protected range
// - program or erase touching protection is ignored
// - write-protect pin only locks protection bits
// - write-protect low freezes protection bits
// - reset needs arm then execute opcodes
// - any other command cancels the armed reset
// - accepted reset restores power-on volatile state
// - reset takes thirty microseconds, commands refused
// - erase clears write latch before finishing
package fwp_pkg;
  // opcodes
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_STATUS_WR = 8'h01;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hd8;
  localparam logic [7:0] OP_ERASE_CHIP_A = 8'h60;
  localparam logic [7:0] OP_ERASE_CHIP_B = 8'hc7;
  localparam logic [7:0] OP_SEC_PROGRAM = 8'h42;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET_EXEC = 8'h99;
  // array geometry and region masks
  localparam int ARRAY_AW = 19;
  localparam logic [18:0] ARRAY_TOP = 19'h7ffff;
  localparam logic [18:0] MASK_PAGE = 19'h000ff;
  localparam logic [18:0] MASK_4K = 19'h00fff;
  localparam logic [18:0] MASK_8K = 19'h01fff;
  localparam logic [18:0] MASK_16K = 19'h03fff;
  localparam logic [18:0] MASK_32K = 19'h07fff;
  localparam logic [18:0] MASK_64K = 19'h0ffff;
  localparam logic [18:0] MASK_128K = 19'h1ffff;
  localparam logic [18:0] MASK_256K = 19'h3ffff;
  // frame length needs, in whole bytes including the opcode
  localparam logic [2:0] BYTES_OPCODE = 3'h1;
  localparam logic [2:0] BYTES_ERASE = 3'h4;
  localparam logic [2:0] BYTES_PROGRAM = 3'h5;
  localparam logic [2:0] BYTES_STATUS = 3'h2;
  localparam logic [2:0] BYTES_STATUS_CMP = 3'h3;
  localparam logic [2:0] BYTES_SAT = 3'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // status-write field positions
  localparam int BP_LSB = 2;
  localparam int CMP_BIT = 6;
  // values after reset
  localparam logic WEL_RESET = 1'b0;
  localparam logic [5:0] PROTECT_RESET = 6'h00;
  // reset recovery time
  localparam int RESET_TIME_NS = 30000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] RESET_LAST = 10'(RESET_CYCLES - 1);

  typedef struct packed {
    logic complement;
    logic granularity;
    logic bottom;
    logic [2:0] size;
  } protect_s;

  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] data1;
    logic [7:0] data2;
    logic [2:0] nbytes;
    logic aligned;
  } frame_s;

  typedef struct packed {
    logic none;
    logic [18:0] lo;
    logic [18:0] hi;
  } range_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_RESET = 3'b100
  } ctrl_state_e;

  // true when [lo,hi] touches the protected range
  function automatic logic overlaps(input logic [18:0] lo, input logic [18:0] hi,
                                    input range_s r);
    overlaps = !r.none && !(hi < r.lo) && !(lo > r.hi);
  endfunction
endpackage

// ==== hw/spi_frame_capture.sv ====
// link-side capture of one chip-select frame: opcode, address and two data bytes
// runs on the host serial clock, which stops between frames
`timescale 1ns/1ps
module spi_frame_capture
  import fwp_pkg::*;
(
  // link
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  input wire logic nrst_in,
  // captured frame, stable while chip select is high
  output frame_s frame_out,
  output logic frame_tog_out
);
  logic started_reg;
  logic [2:0] bit_reg;
  logic [2:0] byte_reg;
  logic [6:0] shift_reg;
  logic [7:0] byte_val;
  logic [2:0] bit_now;
  logic [2:0] byte_now;

  // first edge of a frame restarts the counters
  assign bit_now = started_reg ? bit_reg : 3'h0;
  assign byte_now = started_reg ? byte_reg : 3'h0;
  assign byte_val = {shift_reg, mosi_in};

  // frame-start flag, cleared by chip select so no edge is needed after a frame
  always_ff @(posedge sclk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
      started_reg <= 1'b0;
    else
      started_reg <= 1'b1;
  end

  // toggle once per frame so the system side can tell an empty frame
  always_ff @(posedge sclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      frame_tog_out <= 1'b0;
    else if (!started_reg)
      frame_tog_out <= !frame_tog_out;
  end

  // bit and byte counters; byte count saturates so long frames stay valid
  always_ff @(posedge sclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      bit_reg <= 3'h0;
      byte_reg <= 3'h0;
      shift_reg <= 7'h00;
    end
    else
    begin
      bit_reg <= bit_now + 3'h1;
      shift_reg <= byte_val[6:0];
      if (bit_now == BIT_LAST)
        byte_reg <= (byte_now == BYTES_SAT) ? BYTES_SAT : byte_now + 3'h1;
      else
        byte_reg <= byte_now;
    end
  end

  // byte slots; bytes past the fourth are dropped
  always_ff @(posedge sclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      frame_out <= '0;
    end
    else
    begin
      frame_out.nbytes <= (bit_now == BIT_LAST && byte_now != BYTES_SAT) ?
                          byte_now + 3'h1 : byte_now;
      frame_out.aligned <= (bit_now == BIT_LAST);
      if (bit_now == BIT_LAST)
      begin
        case (byte_now)
          3'h0: frame_out.opcode <= byte_val;
          3'h1:
          begin
            frame_out.addr[23:16] <= byte_val;
            frame_out.data1 <= byte_val;
          end
          3'h2:
          begin
            frame_out.addr[15:8] <= byte_val;
            frame_out.data2 <= byte_val;
          end
          3'h3: frame_out.addr[7:0] <= byte_val;
          default: frame_out.nbytes <= BYTES_SAT;
        endcase
      end
    end
  end
endmodule

// ==== hw/protect_range_decode.sv ====
// decodes the protection bits into one protected address range
// purely combinational, fed from the protection register
`timescale 1ns/1ps
module protect_range_decode
  import fwp_pkg::*;
(
  input protect_s protect_in,
  output range_s range_out
);
  logic [18:0] mask;
  logic none;
  logic all_arr;
  range_s base;

  // size from the low code; granularity picks eighths or kilobytes
  always_comb
  begin
    mask = MASK_4K;
    none = (protect_in.size == 3'h0);
    all_arr = 1'b0;
    if (!protect_in.granularity)
    begin
      case (protect_in.size)
        3'h1: mask = MASK_64K;
        3'h2: mask = MASK_128K;
        3'h3: mask = MASK_256K;
        default: all_arr = !none;
      endcase
    end
    else
    begin
      case (protect_in.size)
        3'h1: mask = MASK_4K;
        3'h2: mask = MASK_8K;
        3'h3: mask = MASK_16K;
        3'h4, 3'h5, 3'h6: mask = MASK_32K;
        default: all_arr = !none;
      endcase
    end
  end

  // place the block at the top or bottom end, then apply the complement
  always_comb
  begin
    base.none = none;
    base.lo = protect_in.bottom ? 19'h00000 : (ARRAY_TOP & ~mask);
    base.hi = protect_in.bottom ? mask : ARRAY_TOP;
    if (all_arr)
    begin
      base.lo = 19'h00000;
      base.hi = ARRAY_TOP;
    end
    range_out = base;
    if (protect_in.complement)
    begin
      if (none)
      begin
        range_out.none = 1'b0;
        range_out.lo = 19'h00000;
        range_out.hi = ARRAY_TOP;
      end
      else if (all_arr)
        range_out.none = 1'b1;
      else if (protect_in.bottom)
      begin
        range_out.lo = mask + 19'h00001;
        range_out.hi = ARRAY_TOP;
      end
      else
      begin
        range_out.lo = 19'h00000;
        range_out.hi = base.lo - 19'h00001;
      end
    end
  end
endmodule

// ==== verif/spi_host_model.sv ====
// spi host model: one chip-select frame per call of frame()
// assumes the device samples data on rising serial clock edges
`timescale 1ns/1ps
module spi_host_model
(
  // link
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out
);
  // serial clock parks low between frames, mode 0
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // shifts nbits of d msb first at a 6 ns period; partial bytes allowed on purpose
  task automatic frame(input logic [39:0] d, input int nbits);
    int i;
    #1.3 cs_n_out = 1'b0;
    for (i = 0; i < nbits; i++)
    begin
      mosi_out = d[39-i];
      #3 sclk_out = 1'b1;
      #3 sclk_out = 1'b0;
    end
    // long gap keeps the last edge well clear of the chip-select rise
    #100 cs_n_out = 1'b1;
    // released line shows the inverse so a stale sample is not mistaken for data
    mosi_out = ~mosi_out;
  endtask
endmodule

// ==== verif/flash_write_protect_and_reset_tb_top.sv ====
// self-checking bench of the write latch, protection and software reset logic
// assumes the host model above on the link and an array sequencer faked here
`timescale 1ns/1ps
module flash_write_protect_and_reset_tb_top;
  import fwp_pkg::*;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic wp_n_in = 1'b1;
  logic op_done_in = 1'b0;
  logic sclk, cs_n, mosi;
  logic op_start_out, write_latch_out, ready_busy_flag_out;
  logic reset_active_out, volatile_clear_out;
  logic [7:0] op_code_out;
  logic [23:0] op_addr_out;
  protect_s protect_out;
  int bad_count = 0;
  int total_checks = 0;
  int ra_cnt = 0;
  int vc_cnt = 0;
  int i;
  logic started = 1'b0;
  logic exp_latch = 1'b0;
  logic [5:0] exp_prot = 6'h00;
  logic [34:0] notes[$];

  spi_host_model i_host (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi));

  flash_write_protect_and_reset i_dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi), .wp_n_in(wp_n_in),
    .op_done_in(op_done_in), .op_start_out(op_start_out), .op_code_out(op_code_out),
    .op_addr_out(op_addr_out), .write_latch_out(write_latch_out),
    .protect_out(protect_out), .ready_busy_flag_out(ready_busy_flag_out),
    .reset_active_out(reset_active_out), .volatile_clear_out(volatile_clear_out));

  // 25 MHz system clock
  initial
  begin
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // pulse counters; the sticky start flag clears while a frame is on the link,
  // so this process is its only driver
  always @(posedge ref_clk_in)
  begin
    if (op_start_out === 1'b1) started <= 1'b1;
    else if (cs_n === 1'b0) started <= 1'b0;
    if (reset_active_out === 1'b1) ra_cnt <= ra_cnt + 1;
    if (volatile_clear_out === 1'b1) vc_cnt <= vc_cnt + 1;
  end

  // result of a frame is settled 8 cycles after chip select rises
  initial
  begin
    forever
    begin
      @(posedge cs_n);
      repeat (8) @(posedge ref_clk_in);
      #1;
      if (notes.size() > 0)
        chk({write_latch_out, started, protect_out, started ? op_code_out : 8'h00,
          started ? op_addr_out[18:0] : 19'h0}, notes.pop_front());
    end
  end

  // own model of the protected map, one 4K sector tested by its base address
  function automatic logic isprot(input logic [5:0] p, input logic [18:0] a);
    logic [19:0] sz;
    logic hit;
    if (p[4])
      sz = (p[2:0] == 3'h7) ? 20'h80000 : p[2] ? 20'h08000 : 20'h00800 << p[1:0];
    else
      sz = p[2] ? 20'h80000 : 20'h08000 << p[1:0];
    hit = (p[2:0] != 3'h0) && (p[3] ? {1'b0, a} < sz : {1'b0, a} >= 20'h80000 - sz);
    return hit ^ p[5];
  endfunction

  // expected state after the frame is noted before the frame is sent
  task automatic cmd(input logic [39:0] d, input int nb, input logic st, input logic [26:0] oa);
    notes.push_back({exp_latch, st, exp_prot, st ? oa : 27'h0});
    i_host.frame(d, nb);
    repeat (12) @(negedge ref_clk_in);
  endtask

  task automatic wen();
    exp_latch = 1'b1;
    cmd({OP_LATCH_SET, 32'h0}, 8, 1'b0, 27'h0);
  endtask

  // status write consumes the latch; wp low keeps the bits
  task automatic status(input logic [5:0] p);
    if (exp_latch && wp_n_in) exp_prot = p;
    exp_latch = 1'b0;
    cmd({OP_STATUS_WR, 1'b0, p[4:0], 2'b00, 1'b0, p[5], 6'h00, 16'h0}, 24, 1'b0, 27'h0);
  endtask

  // any protected 4K sector inside the region of n4k sectors holding a
  function automatic logic region_prot(input logic [5:0] p, input logic [18:0] a,
                                       input int n4k);
    logic any;
    any = 1'b0;
    for (int k = 0; k < n4k; k++)
      any |= isprot(p, 19'(a / (n4k * 4096) * (n4k * 4096) + k * 4096));
    return any;
  endfunction

  // every guarded opcode class the design decodes, taken in turn
  function automatic logic [7:0] pick_op(input int k);
    case (k % 8)
      0: return OP_PROGRAM;
      1: return OP_ERASE_32K;
      2: return OP_ERASE_64K;
      3: return OP_ERASE_CHIP_A;
      4: return OP_ERASE_CHIP_B;
      5: return OP_SEC_PROGRAM;
      6: return OP_SEC_ERASE;
      default: return OP_ERASE_4K;
    endcase
  endfunction

  // program and erase family; chip erase carries trailing address bytes it ignores,
  // security ops see no array protection; the fake sequencer ends each accepted op
  task automatic guarded(input logic [7:0] op, input logic [18:0] a);
    logic st;
    int n4k;
    int nb;
    nb = (op == OP_PROGRAM || op == OP_SEC_PROGRAM) ? 40 : 32;
    n4k = (op == OP_ERASE_32K) ? 8 : (op == OP_ERASE_64K) ? 16 : (op == OP_SEC_PROGRAM ||
      op == OP_SEC_ERASE) ? 0 : (op == OP_ERASE_CHIP_A || op == OP_ERASE_CHIP_B) ? 128 : 1;
    st = exp_latch && !region_prot(exp_prot, a, n4k);
    if (st) exp_latch = 1'b0;
    cmd({op, 5'h0, a, 8'h0}, nb, st, {op, a});
    if (st)
    begin
      chk(ready_busy_flag_out, 1'b1);
      op_done_in = 1'b1;
      @(negedge ref_clk_in);
      op_done_in = 1'b0;
      repeat (3) @(negedge ref_clk_in);
      chk(ready_busy_flag_out, 1'b0);
    end
  endtask

  initial
  begin
    #2000000;
    bad_count++;
    print_verdict();
  end

  initial
  begin
    void'($urandom(57016));
    repeat (8) @(negedge ref_clk_in);
    nrst_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    // trailing byte ignored, partial frames leave the latch alone
    exp_latch = 1'b1;
    cmd({OP_LATCH_SET, 8'ha5, 24'h0}, 16, 1'b0, 27'h0);
    cmd({OP_LATCH_CLR, 32'h0}, 5, 1'b0, 27'h0);
    cmd({OP_LATCH_CLR, 32'h0}, 11, 1'b0, 27'h0);
    exp_latch = 1'b0;
    cmd({OP_LATCH_CLR, 32'h0}, 8, 1'b0, 27'h0);
    cmd({OP_LATCH_SET, 32'h0}, 12, 1'b0, 27'h0);
    guarded(OP_ERASE_4K, 19'h12345);
    status(6'h2a);
    $display("test latch done");
    // random protection codes, program and erase attempts with the pin at either level
    for (i = 0; i < 24; i++)
    begin
      wen();
      status(6'($urandom()));
      wp_n_in = 1'($urandom());
      wen();
      guarded(pick_op(i), 19'($urandom()));
      wp_n_in = 1'b1;
    end
    // pin low freezes the protection bits
    wp_n_in = 1'b0;
    wen();
    status(~exp_prot);
    wp_n_in = 1'b1;
    $display("test protect done");
    // armed reset cancelled by another command
    wen();
    cmd({OP_RESET_ARM, 32'h0}, 8, 1'b0, 27'h0);
    exp_latch = 1'b0;
    cmd({OP_LATCH_CLR, 32'h0}, 8, 1'b0, 27'h0);
    cmd({OP_RESET_EXEC, 32'h0}, 8, 1'b0, 27'h0);
    chk(35'(vc_cnt), 35'h0);
    // accepted reset, with the host first confirming the device is idle
    wen();
    chk(ready_busy_flag_out, 1'b0);
    cmd({OP_RESET_ARM, 32'h0}, 8, 1'b0, 27'h0);
    exp_latch = 1'b0;
    cmd({OP_RESET_EXEC, 32'h0}, 8, 1'b0, 27'h0);
    chk(35'(vc_cnt), 35'h1);
    chk(reset_active_out, 1'b1);
    cmd({OP_LATCH_SET, 32'h0}, 8, 1'b0, 27'h0);
    for (i = 0; i < 1000 && reset_active_out !== 1'b0; i++) @(negedge ref_clk_in);
    chk(35'(ra_cnt), 35'(RESET_CYCLES));
    wen();
    $display("test reset done");
    repeat (20) @(negedge ref_clk_in);
    print_verdict();
  end
endmodule
